// [src/svd_pkg.sv]
// constants, state layout and address decode of the supply trip detector
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port
package svd_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;

  // voltage_detect_control fields
  localparam int DIR_BIT = 7;
  localparam int BGAP_BIT = 6;
  localparam int REFST_BIT = 5;
  localparam int EN_BIT = 4;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h5;
  localparam logic [LEVEL_W-1:0] LEVEL_EXT = 4'hf;
  localparam logic DIR_RST = 1'b0;
  localparam logic EN_RST = 1'b0;

  // status and mask layout
  localparam int EVT_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reference start-up interval
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIRVST_NS = 20000;
  localparam int STAB_CYCLES = (TIRVST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_W = 12;

  localparam int SYNC_W = 4;

  typedef struct packed {
    logic dir;
    logic en;
    logic [LEVEL_W-1:0] level;
    logic [STAB_W-1:0] stab_cnt;
    logic cond_prev;
    logic flag;
    logic irq_en;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } svd_state_s;

  // one-hot {mask, status, control}; zero for an unmapped address
  function automatic logic [2:0] svd_decode(input logic [ADDR_W-1:0] a);
    svd_decode = {a == MASK_OFS, a == STAT_OFS, a == CTRL_OFS};
  endfunction

endpackage

// [src/svd_sync.sv]
// two-flop synchroniser for a group of independent levels
// assumes each input bit is a slow level, not a bus word
`timescale 1ns/1ps
module svd_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } svd_sync_s;

  svd_sync_s st_r;
  svd_sync_s st_nxt;

  initial begin
    if (WIDTH < 1) $error("svd_sync: WIDTH must be at least one");
  end

  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule // svd_sync

// [src/svd_top.sv]
// supply trip detector: control register, start-up timer, event flag, irq
// assumes the analog comparator, divider and reference sit outside
//
// Summary of operation
// R1: direction clear: fall to trip point is event
// R2: direction set: rise to trip point is event
// R3: enable powers detector, starts stabilisation interval
// R4: disabled detector is powered down, no events
// R5: read-only reference stable bit after interval
// R6: no flag while reference not yet stable
// R7: four-bit level, top code selects external input
// R8: read-only bandgap stable status bit
// R9: configured crossing sets flag, irq if enabled
// R10: event flag in bit two, software clears
// R11: level all ones routes external trip input
// R12: reset returns control register, detector off
// R13: software disables detector before changing settings
// R14: comparator and stable indications synchronised first
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module svd_top
  import svd_pkg::*;
#(
  parameter int STAB_CYCLES_P = svd_pkg::STAB_CYCLES
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [svd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [svd_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [svd_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [svd_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // analog side
  input wire logic cmp_at_or_below_in,
  input wire logic cmp_at_or_above_in,
  input wire logic ref_ready_in,
  input wire logic bandgap_ok_in,
  output logic detector_power_out,
  output logic trip_direction_out,
  output logic [svd_pkg::LEVEL_W-1:0] trip_level_out,
  output logic external_trip_sel_out,
  output logic irq_out
);

  initial begin
    if (STAB_CYCLES_P < 1 || STAB_CYCLES_P >= (1 << STAB_W))
      $error("svd_top: STAB_CYCLES_P out of range");
  end

  //////////////////////////////////////////////////////////////////////////////

  svd_state_s st_r;
  svd_state_s st_nxt;
  logic [SYNC_W-1:0] sync_q;
  logic below_s;
  logic above_s;
  logic ref_ok_s;
  logic bgap_s;
  logic ref_stable;
  logic cond;
  logic event_set;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [DATA_W-1:0] ctrl_word;

  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES_P);

  svd_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .async_in({bandgap_ok_in, ref_ready_in, cmp_at_or_above_in, cmp_at_or_below_in}),
    .sync_out(sync_q)
  ); // R14

  assign below_s = sync_q[0];
  assign above_s = sync_q[1];
  assign ref_ok_s = sync_q[2];
  assign bgap_s = sync_q[3];

  //////////////////////////////////////////////////////////////////////////////

  assign ref_stable = st_r.en && (st_r.stab_cnt == STAB_LAST) && ref_ok_s; // R5
  assign cond = st_r.dir ? above_s : below_s; // R1 R2
  assign event_set = ref_stable && cond && !st_r.cond_prev; // R6 R9

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_sel = svd_decode(st_r.aw_addr);
  assign rd_sel = svd_decode(s_axi_araddr);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[DIR_BIT] = st_r.dir;
    ctrl_word[BGAP_BIT] = bgap_s; // R8
    ctrl_word[REFST_BIT] = ref_stable; // R5
    ctrl_word[EN_BIT] = st_r.en;
    ctrl_word[LEVEL_LSB +: LEVEL_W] = st_r.level;
  end

  always_comb begin
    st_nxt = st_r;
    // start-up timer restarts on every enable
    if (!st_r.en) begin
      st_nxt.stab_cnt = '0; // R3 R4
    end else if (st_r.stab_cnt != STAB_LAST) begin
      st_nxt.stab_cnt = st_r.stab_cnt + 1'b1; // R3
    end
    // edge detector only armed while stable, so enabling at a trip level fires once
    st_nxt.cond_prev = ref_stable && cond; // R6
    // write channel capture
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      if (st_r.w_strb[0]) begin
        if (wr_sel[0]) begin
          st_nxt.dir = st_r.w_data[DIR_BIT];
          st_nxt.en = st_r.w_data[EN_BIT]; // R3
          st_nxt.level = st_r.w_data[LEVEL_LSB +: LEVEL_W]; // R7
        end
        if (wr_sel[1] && st_r.w_data[EVT_BIT]) begin
          st_nxt.flag = 1'b0; // R10
        end
        if (wr_sel[2]) begin
          st_nxt.irq_en = st_r.w_data[EVT_BIT];
        end
      end
    end
    // set wins over a clear in the same cycle
    if (event_set) begin
      st_nxt.flag = 1'b1; // R9 R10
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = (rd_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      st_nxt.rdata = '0;
      if (rd_sel[0]) begin
        st_nxt.rdata = ctrl_word;
      end
      if (rd_sel[1]) begin
        st_nxt.rdata[EVT_BIT] = st_r.flag;
      end
      if (rd_sel[2]) begin
        st_nxt.rdata[EVT_BIT] = st_r.irq_en;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.dir <= DIR_RST; // R12
      st_r.en <= EN_RST; // R12
      st_r.level <= LEVEL_RST; // R12
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign detector_power_out = st_r.en; // R4
  assign trip_direction_out = st_r.dir;
  assign trip_level_out = st_r.level;
  assign external_trip_sel_out = (st_r.level == LEVEL_EXT); // R11
  assign irq_out = st_r.flag && st_r.irq_en; // R9

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  sequence en_switched_on;
    $rose(st_r.en);
  endsequence

  sequence low_crossing;
    ref_stable && !st_r.dir && below_s && !st_r.cond_prev;
  endsequence

  sequence high_crossing;
    ref_stable && st_r.dir && above_s && !st_r.cond_prev;
  endsequence

  sequence ctrl_read;
    ar_hs && rd_sel[0];
  endsequence

  sequence stat_read;
    ar_hs && rd_sel[1];
  endsequence

  low_event_a: assert property (low_crossing |=> st_r.flag) // R1
    else $error("fall to trip point did not set the flag");

  high_event_a: assert property (high_crossing |=> st_r.flag) // R2
    else $error("rise to trip point did not set the flag");

  stab_wait_a: assert property (en_switched_on |-> !ref_stable [*8]) // R3
    else $error("reference stable too soon after enable");

  off_quiet_a: assert property (!st_r.en |-> !detector_power_out ##1 !$rose(st_r.flag)) // R4
    else $error("event or power while detector disabled");

  refst_read_a: assert property (ref_stable |-> st_r.en && st_r.stab_cnt == STAB_LAST && $past(st_r.en)) // R5
    else $error("reference stable without completed interval");

  gate_flag_a: assert property ($rose(st_r.flag) |-> $past(ref_stable)) // R6
    else $error("flag set before reference stable");

  ext_select_a: assert property (external_trip_sel_out == (trip_level_out == 4'hf)) // R7 R11
    else $error("external input select wrong");

  bgap_read_a: assert property (ar_hs && rd_sel[0] |=> s_axi_rdata[BGAP_BIT] == $past(bgap_s)) // R8
    else $error("bandgap status read wrong");

  irq_raise_a: assert property (event_set && st_r.irq_en && !(wr_fire && wr_sel[2]) |=> irq_out) // R9
    else $error("enabled event did not raise irq");

  set_wins_a: assert property (event_set && wr_fire && wr_sel[1] |=> st_r.flag) // R10
    else $error("event lost against a clear");

  clear_flag_a: assert property (wr_fire && wr_sel[1] && st_r.w_strb[0] && st_r.w_data[EVT_BIT] && !event_set
    |=> !st_r.flag) // R10
    else $error("write one did not clear the flag");

  reset_ctrl_a: assert property (@(posedge clock_in) disable iff (1'b0)
    !nrst_in |=> !st_r.en && st_r.level == LEVEL_RST && !st_r.dir) // R12
    else $error("control not at reset value");

  sync_delay_a: assert property ($past(nrst_in) && $past(nrst_in, 2) |-> below_s == $past(cmp_at_or_below_in, 2)) // R14
    else $error("comparator not delayed by two flops");

  counter_clear_a: assert property (!st_r.en |=> st_r.stab_cnt == '0) // R4
    else $error("start-up counter running while disabled");

  stab_count_a: assert property (st_r.en && st_r.stab_cnt != STAB_LAST // R3
    |=> st_r.stab_cnt == $past(st_r.stab_cnt) + 1'b1)
    else $error("start-up counter did not advance");

  en_power_a: assert property (wr_fire && wr_sel[0] && st_r.w_strb[0] // R3
    && st_r.w_data[EN_BIT] |=> detector_power_out)
    else $error("enable write did not power the detector");

  refst_view_a: assert property (ctrl_read |=> s_axi_rdata[REFST_BIT] == $past(ref_stable)) // R5
    else $error("reference stable read wrong");

  cond_arm_a: assert property (!ref_stable |=> !st_r.cond_prev) // R6
    else $error("edge detector armed before reference stable");

  level_hold_a: assert property (!(wr_fire && wr_sel[0]) // R7
    |=> $stable(trip_level_out) && $stable(trip_direction_out))
    else $error("settings changed without a control write");

  flag_sticky_a: assert property (st_r.flag // R10
    && !(wr_fire && wr_sel[1] && st_r.w_strb[0] && st_r.w_data[EVT_BIT]) |=> st_r.flag)
    else $error("event flag lost without a clear");

  stat_read_a: assert property (stat_read |=> s_axi_rdata[EVT_BIT] == $past(st_r.flag)) // R10
    else $error("event flag read wrong");

  power_off_a: assert property (@(posedge clock_in) disable iff (1'b0) // R12
    !nrst_in |=> !detector_power_out && !irq_out)
    else $error("detector or irq active after reset");

endmodule // svd_top

// [test/supply_voltage_trip_detector_bench.sv]
// self-checking bench of svd_top with the analog side model
// assumes a start-up count shortened to 10 cycles
`timescale 1ns/1ps
module supply_voltage_trip_detector_bench;
  import svd_pkg::*;
  logic clock_in = 0, nrst_in = 0, bg = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf, lvl_out;
  logic awready, wready, bvalid, arready, rvalid, below, above, ref_ok, pwr, dir_out, ext, irq;
  logic [1:0] bresp, rresp;
  int volt = 300, n_fail = 0, checked = 0, cyc = 0, seed = 32'h3e09e77f, dir = 0, en = 0, lvl = 5;
  svd_top #(.STAB_CYCLES_P(10)) svd_top_inst (.clock_in(clock_in), .nrst_in(nrst_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .cmp_at_or_below_in(below), .cmp_at_or_above_in(above), .ref_ready_in(ref_ok),
    .bandgap_ok_in(bg), .detector_power_out(pwr), .trip_direction_out(dir_out), .trip_level_out(lvl_out),
    .external_trip_sel_out(ext), .irq_out(irq));
  svd_analog_model svd_analog_model_inst (.clock_in(clock_in), .power_in(pwr), .level_in(lvl_out),
    .ext_sel_in(ext), .volt_in(volt), .below_out(below), .above_out(above), .ref_ok_out(ref_ok));
  initial forever #4 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input int rs);
    return {24'h0, dir[0], bg, rs[0], en[0], lvl[3:0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_in);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= d;
    forever begin
      @(posedge clock_in);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    cmp(bresp, er, "bresp");
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock_in);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    forever begin
      @(posedge clock_in);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    cmp(rdata, e, "rdata");
    cmp(rresp, er, "rresp");
  endtask
  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock_in);
    nrst_in <= 1;
    rchk(CTRL_OFS, ctl(0), RESP_OKAY);
    rchk(STAT_OFS, 0, RESP_OKAY);
    rchk(4'hc, 0, RESP_SLVERR);
    cmp(irq, 0, "irq");
    $display("reset test done");
    bg <= 1;
    for (int i = 0; i < 5; i++) begin
      lvl = i == 4 ? 15 : $random(seed) & 15;
      dir = $random(seed) & 1;
      wchk(CTRL_OFS, ctl(0) | 32'h60, RESP_OKAY);
      rchk(CTRL_OFS, ctl(0), RESP_OKAY);
      cmp(ext, lvl == 15, "ext sel");
      cmp(lvl_out, lvl, "level");
      cmp(dir_out, dir, "dir");
    end
    $display("field test done");
    dir = 0;
    lvl = 5;
    wchk(CTRL_OFS, ctl(0), RESP_OKAY);
    repeat (3) begin
      volt <= 0;
      repeat (5) @(posedge clock_in);
      volt <= 300;
      repeat (5) @(posedge clock_in);
    end
    rchk(STAT_OFS, 0, RESP_OKAY);
    cmp(pwr, 0, "power");
    en = 1;
    wchk(CTRL_OFS, ctl(0), RESP_OKAY);
    volt <= 0;
    @(posedge clock_in);
    volt <= 300;
    rchk(CTRL_OFS, ctl(0), RESP_OKAY);
    repeat (30) @(posedge clock_in);
    rchk(CTRL_OFS, ctl(1), RESP_OKAY);
    rchk(STAT_OFS, 0, RESP_OKAY);
    cmp(pwr, 1, "power");
    $display("start-up test done");
    wchk(MASK_OFS, 4, RESP_OKAY);
    wchk(STAT_OFS, 4, RESP_OKAY);
    cmp(irq, 0, "irq");
    volt <= 150;
    repeat (8) @(posedge clock_in);
    rchk(STAT_OFS, 4, RESP_OKAY);
    cmp(irq, 1, "irq");
    wchk(MASK_OFS, 0, RESP_OKAY);
    cmp(irq, 0, "irq masked");
    volt <= 300;
    wchk(STAT_OFS, 4, RESP_OKAY);
    rchk(STAT_OFS, 0, RESP_OKAY);
    $display("fall test done");
    en = 0;
    wchk(CTRL_OFS, ctl(0), RESP_OKAY);
    dir = 1;
    en = 1;
    volt <= 0;
    wchk(CTRL_OFS, ctl(0), RESP_OKAY);
    wchk(MASK_OFS, 4, RESP_OKAY);
    repeat (30) @(posedge clock_in);
    rchk(STAT_OFS, 0, RESP_OKAY);
    volt <= 150;
    repeat (8) @(posedge clock_in);
    rchk(STAT_OFS, 4, RESP_OKAY);
    cmp(irq, 1, "irq");
    $display("rise test done");
    nrst_in <= 0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1;
    dir = 0;
    en = 0;
    repeat (3) @(posedge clock_in);
    rchk(CTRL_OFS, ctl(0), RESP_OKAY);
    rchk(STAT_OFS, 0, RESP_OKAY);
    rchk(MASK_OFS, 0, RESP_OKAY);
    cmp(pwr, 0, "power");
    cmp(irq, 0, "irq");
    $display("mid-run reset test done");
    conclude();
  end
endmodule // supply_voltage_trip_detector_bench

// [test/svd_analog_model.sv]
// analog side model: comparator, divider and reference start-up
// assumes the bench sets the monitored level as an integer
`timescale 1ns/1ps
module svd_analog_model (
  input wire logic clock_in,
  input wire logic power_in,
  input wire logic [3:0] level_in,
  input wire logic ext_sel_in,
  input var int volt_in,
  output logic below_out,
  output logic above_out,
  output logic ref_ok_out
);
  int cnt = 0;
  int trip;
  initial {below_out, above_out, ref_ok_out} = 3'b010;
  always_comb trip = ext_sel_in ? 50 : 100 + 10 * level_in;
  always @(posedge clock_in) begin
    cnt <= power_in === 1'b1 ? cnt + 1 : 0;
    ref_ok_out <= power_in === 1'b1 && cnt >= 3;
    // unpowered comparator output is garbage, but never unknown
    below_out <= power_in === 1'b1 ? volt_in <= trip : !below_out;
    above_out <= power_in === 1'b1 ? volt_in >= trip : !above_out;
  end
endmodule // svd_analog_model
